//--- dtx_pkg.sv
package dtx_pkg;
  // =====================================================
  // register indices, byte address is index times four
  localparam int ADDR_LSB = 2;
  localparam int IDX_W = 12;
  localparam logic [11:0] IDX_DL_CTRL = 12'h113;
  localparam logic [11:0] IDX_BYTE_CNT = 12'h114;
  localparam logic [11:0] IDX_IRQ_STAT = 12'h118;
  localparam logic [11:0] IDX_IRQ_MASK = 12'h119;
  localparam logic [11:0] IDX_BUF0 = 12'h600;
  localparam logic [11:0] IDX_BUF1 = 12'h700;
  localparam int BUF_LSB = 7;
  localparam int BUF_SEL_BIT = 8;
  // =====================================================
  // field positions and widths
  localparam int CTL_MOS_BIT = 0;
  localparam int CTL_FCS_BIT = 1;
  localparam int BC_SEL_BIT = 7;
  localparam int CNT_W = 7;
  localparam int IRQ_EOT_BIT = 0;
  localparam int IRQ_FRM_BIT = 1;
  localparam int IRQ_W = 2;
  // =====================================================
  // line constants
  localparam logic [7:0] FLAG_OCTET = 8'h7E;
  localparam logic [7:0] BOS_LEAD = 8'hFF;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [2:0] STUFF_RUN = 3'h5;
  localparam logic [4:0] BYTE_BITS = 5'h08;
  localparam logic [4:0] CRC_BITS = 5'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // =====================================================
  // timing: one data link bit lasts 250 us
  localparam int BIT_TIME_NS = 250000;
  localparam int CLK_NS = 25;
  localparam int BIT_CYC = BIT_TIME_NS / CLK_NS;
  typedef enum logic [1:0] {KIND_RAW, KIND_DATA, KIND_CRC} dtx_kind_e;
endpackage

//--- dtx_if.sv
`timescale 1ns/1ps
// =====================================================
// octet stream from control to line shifter
interface dtx_byte_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  dtx_pkg::dtx_kind_e kind;
  modport src (output valid, data, kind, input ready);
  modport snk (input valid, data, kind, output ready);
endinterface

// =====================================================
// message buffer ports
interface dtx_mem_if;
  logic we;
  logic [7:0] waddr;
  logic [7:0] wdata;
  logic re;
  logic [7:0] raddr;
  logic [7:0] rdata;
  modport ctl (output we, waddr, wdata, re, raddr, input rdata);
  modport mem (input we, waddr, wdata, re, raddr, output rdata);
endinterface

//--- dtx_msg_ram.sv
`timescale 1ns/1ps
// =====================================================
// two message buffers of 128 octets, registered read
module dtx_msg_ram #(
  parameter int DEPTH = 256
) (
  input wire logic clk_i,
  dtx_mem_if.mem m
);
  import dtx_pkg::*;
  logic [7:0] mem_r [DEPTH];

  // write port from software, read port to transmitter
  always_ff @(posedge clk_i)
  begin
    if (m.we)
    begin
      mem_r[m.waddr] <= m.wdata;
    end
    if (m.re)
    begin
      m.rdata <= mem_r[m.raddr];
    end
  end
endmodule

//--- dtx_bit_shifter.sv
`timescale 1ns/1ps
// =====================================================
// serialiser with zero insertion and frame check
module dtx_bit_shifter (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic bit_en_i,
  dtx_byte_if.snk b,
  output logic dl_data_o
);
  import dtx_pkg::*;
  logic [15:0] sh_r;
  logic [4:0] left_r;
  logic raw_r;
  logic hold_r;
  logic [2:0] ones_r;
  logic [15:0] crc_r;

  // reflected crc, one bit lsb first
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic d);
    logic [15:0] n;
    n = c >> 1;
    if (c[0] ^ d)
    begin
      n = n ^ CRC_POLY;
    end
    return n;
  endfunction

  // stuffing and handshake terms
  wire stuff = !raw_r && (ones_r == STUFF_RUN);
  wire take = b.valid && b.ready;
  wire send = bit_en_i && (stuff || (left_r != 5'h00));
  assign b.ready = (left_r == 5'h00) && !stuff;

  // load octets, shift one bit per strobe
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sh_r <= 16'h0000;
      left_r <= 5'h00;
      raw_r <= 1'b1;
      hold_r <= 1'b0;
      ones_r <= 3'h0;
      crc_r <= CRC_INIT;
      dl_data_o <= 1'b1;
    end
    else if (take)
    begin
      raw_r <= (b.kind == KIND_RAW);
      hold_r <= (b.kind == KIND_CRC);
      if (b.kind == KIND_CRC)
      begin
        sh_r <= ~crc_r;
        left_r <= CRC_BITS;
      end
      else
      begin
        sh_r <= {8'h00, b.data};
        left_r <= BYTE_BITS;
      end
      if (b.kind == KIND_RAW)
      begin
        crc_r <= CRC_INIT;
        ones_r <= 3'h0;
      end
    end
    else if (send)
    begin
      if (stuff)
      begin
        dl_data_o <= 1'b0;
        ones_r <= 3'h0;
      end
      else
      begin
        dl_data_o <= sh_r[0];
        sh_r <= sh_r >> 1;
        left_r <= left_r - 5'h01;
        if (!raw_r)
        begin
          ones_r <= sh_r[0] ? ones_r + 3'h1 : 3'h0;
        end
        if (!raw_r && !hold_r)
        begin
          crc_r <= crc_step(crc_r, sh_r[0]);
        end
      end
    end
    else if (bit_en_i)
    begin
      dl_data_o <= 1'b1;
    end
  end
endmodule

//--- dtx_top.sv
`timescale 1ns/1ps
// =====================================================
// data link transmit control with axi4-lite registers
module dtx_top #(
  parameter int ADDR_W = 16,
  parameter int BIT_CYC = dtx_pkg::BIT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic dl_data_o,
  output logic dl_bit_en_o,
  output logic tx_end_of_transfer_irq_o
);
  import dtx_pkg::*;
  localparam int DIV_W = $clog2(BIT_CYC);

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_MREAD = 6'b000010,
    ST_MPUSH = 6'b000100,
    ST_CRC   = 6'b001000,
    ST_BLEAD = 6'b010000,
    ST_BCODE = 6'b100000
  } dtx_state_e;

  // buffer window test, shared by read and write decode
  function automatic logic buf_hit(input logic [IDX_W-1:0] idx);
    return (idx[IDX_W-1:BUF_LSB] == IDX_BUF0[IDX_W-1:BUF_LSB])
        || (idx[IDX_W-1:BUF_LSB] == IDX_BUF1[IDX_W-1:BUF_LSB]);
  endfunction

  dtx_byte_if byte_ch ();
  dtx_mem_if mem_ch ();

  // =====================================================
  // bit rate divider
  logic [DIV_W-1:0] div_r;
  wire bit_en = (div_r == DIV_W'(BIT_CYC - 1));

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      div_r <= '0;
    else
      div_r <= bit_en ? '0 : div_r + 1'b1;
  end
  assign dl_bit_en_o = bit_en;

  // =====================================================
  // axi write channels
  logic aw_hold_r;
  logic w_hold_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [7:0] w_data_r;
  logic w_lane_r;
  logic bvalid_r;
  logic [1:0] bresp_r;

  assign s_axi_awready_o = !aw_hold_r;
  assign s_axi_wready_o = !w_hold_r;
  assign s_axi_bvalid_o = bvalid_r;
  assign s_axi_bresp_o = bresp_r;

  // write decode
  wire wr_fire = aw_hold_r && w_hold_r && !bvalid_r;
  wire [IDX_W-1:0] wr_idx = aw_addr_r[ADDR_LSB +: IDX_W];
  wire wr_go = wr_fire && w_lane_r;
  wire wr_ctl = wr_go && (wr_idx == IDX_DL_CTRL);
  wire wr_cnt = wr_go && (wr_idx == IDX_BYTE_CNT);
  wire wr_stat = wr_go && (wr_idx == IDX_IRQ_STAT);
  wire wr_mask = wr_go && (wr_idx == IDX_IRQ_MASK);
  wire wr_buf = wr_go && buf_hit(wr_idx);
  wire wr_hit = (wr_idx == IDX_DL_CTRL) || (wr_idx == IDX_BYTE_CNT)
             || (wr_idx == IDX_IRQ_STAT) || (wr_idx == IDX_IRQ_MASK)
             || buf_hit(wr_idx);

  // address and data taken in either order
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= 8'h00;
      w_lane_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid_i && !aw_hold_r)
      begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && !w_hold_r)
      begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata_i[7:0];
        w_lane_r <= s_axi_wstrb_i[0];
      end
      if (wr_fire)
      begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_r && s_axi_bready_i)
      begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // =====================================================
  // control registers and buffer ownership
  logic mos_r;
  logic fcs_en_r;
  logic [CNT_W-1:0] cnt_r;
  logic sel_r;
  logic [1:0] busy_r;
  logic free_ptr_r;
  logic [IRQ_W-1:0] stat_r;
  logic [IRQ_W-1:0] mask_r;
  logic pend_r;
  logic pend_mos_r;
  logic pend_sel_r;
  logic [CNT_W-1:0] pend_len_r;
  logic free_fire;
  logic cur_sel_r;
  logic [IRQ_W-1:0] irq_set;
  dtx_state_e state_r;

  // a start names the buffer and length last written
  wire cmd_mos = wr_cnt && mos_r;
  wire cmd_bos = wr_ctl && !w_data_r[CTL_MOS_BIT];
  wire cmd_sel = wr_cnt ? w_data_r[BC_SEL_BIT] : sel_r;
  wire [CNT_W-1:0] cmd_len = wr_cnt ? w_data_r[CNT_W-1:0] : cnt_r;
  wire cmd_ok = (cmd_mos || cmd_bos) && !busy_r[cmd_sel] && !pend_r;
  wire next_free = busy_r[free_ptr_r] ? !free_ptr_r : free_ptr_r;
  wire [IRQ_W-1:0] stat_clr = wr_stat ? w_data_r[IRQ_W-1:0] : '0;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mos_r <= 1'b0;
      fcs_en_r <= 1'b0;
      cnt_r <= '0;
      sel_r <= 1'b0;
      mask_r <= '0;
      stat_r <= '0;
    end
    else
    begin
      if (wr_ctl)
      begin
        mos_r <= w_data_r[CTL_MOS_BIT];
        fcs_en_r <= w_data_r[CTL_FCS_BIT];
      end
      if (wr_cnt)
      begin
        cnt_r <= w_data_r[CNT_W-1:0];
        sel_r <= w_data_r[BC_SEL_BIT];
      end
      if (wr_mask)
        mask_r <= w_data_r[IRQ_W-1:0];
      stat_r <= (stat_r & ~stat_clr) | irq_set; // set beats clear
    end
  end

  // pending command and buffer busy flags
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pend_r <= 1'b0;
      pend_mos_r <= 1'b0;
      pend_sel_r <= 1'b0;
      pend_len_r <= '0;
      busy_r <= 2'h0;
      free_ptr_r <= 1'b0;
    end
    else
    begin
      if (free_fire)
        busy_r[cur_sel_r] <= 1'b0;
      if (cmd_ok)
      begin
        pend_r <= 1'b1;
        pend_mos_r <= cmd_mos;
        pend_sel_r <= cmd_sel;
        pend_len_r <= cmd_len;
        busy_r[cmd_sel] <= 1'b1;
        free_ptr_r <= !cmd_sel;
      end
      else if (byte_ch.ready && state_r == ST_IDLE)
      begin
        pend_r <= 1'b0;
      end
    end
  end

  assign tx_end_of_transfer_irq_o = |(stat_r & mask_r);

  // =====================================================
  // axi read channel
  logic rvalid_r;
  logic [7:0] rdata_r;
  logic [1:0] rresp_r;
  logic [7:0] rd_val;
  logic rd_hit;
  wire [IDX_W-1:0] rd_idx = s_axi_araddr_i[ADDR_LSB +: IDX_W];

  // read mux, reserved bits zero, buffers read as zero
  always_comb
  begin
    rd_val = 8'h00;
    rd_hit = 1'b1;
    if (rd_idx == IDX_DL_CTRL)
    begin
      rd_val[CTL_MOS_BIT] = mos_r;
      rd_val[CTL_FCS_BIT] = fcs_en_r;
    end
    else if (rd_idx == IDX_BYTE_CNT)
      rd_val = {next_free, cnt_r};
    else if (rd_idx == IDX_IRQ_STAT)
      rd_val[IRQ_W-1:0] = stat_r;
    else if (rd_idx == IDX_IRQ_MASK)
      rd_val[IRQ_W-1:0] = mask_r;
    else if (!buf_hit(rd_idx))
      rd_hit = 1'b0;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= 8'h00;
      rresp_r <= RESP_OKAY;
    end
    else if (s_axi_arvalid_i && !rvalid_r)
    begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_val;
      rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_r && s_axi_rready_i)
    begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_arready_o = !rvalid_r;
  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rdata_o = {24'h000000, rdata_r};
  assign s_axi_rresp_o = rresp_r;

  // =====================================================
  // transmit sequencer
  logic cur_mos_r;
  logic cur_fcs_r;
  logic [CNT_W-1:0] cur_len_r;
  logic [CNT_W-1:0] idx_r;
  logic [CNT_W-1:0] rep_r;

  wire take = byte_ch.valid && byte_ch.ready;
  wire [CNT_W-1:0] idx_inc = idx_r + 1'b1;
  wire [CNT_W-1:0] rep_inc = rep_r + 1'b1;
  wire last_oct = (idx_inc == cur_len_r);
  wire bos_done = (cur_len_r != '0) && (rep_inc == cur_len_r);
  wire bos_stop = pend_r || mos_r;
  wire len_zero = cur_mos_r && (cur_len_r == '0);

  // octet offered to the shifter per state
  always_comb
  begin
    byte_ch.valid = 1'b1;
    byte_ch.kind = KIND_RAW;
    byte_ch.data = FLAG_OCTET;
    case (state_r)
      ST_MREAD: byte_ch.valid = 1'b0;
      ST_MPUSH:
      begin
        byte_ch.kind = KIND_DATA;
        byte_ch.data = mem_ch.rdata;
      end
      ST_CRC: byte_ch.kind = KIND_CRC;
      ST_BLEAD: byte_ch.data = BOS_LEAD;
      ST_BCODE: byte_ch.data = mem_ch.rdata;
      default: byte_ch.valid = 1'b1;
    endcase
  end

  // buffer release and interrupt events
  assign free_fire = (state_r == ST_MREAD && len_zero)
                  || (state_r == ST_MPUSH && take && last_oct)
                  || (state_r == ST_BCODE && take && (bos_done || bos_stop));
  assign irq_set[IRQ_EOT_BIT] = state_r == ST_BCODE && take && bos_done;
  assign irq_set[IRQ_FRM_BIT] = (state_r == ST_CRC && take)
                             || (state_r == ST_MPUSH && take && last_oct && !cur_fcs_r)
                             || (state_r == ST_MREAD && len_zero);

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_r <= ST_IDLE;
      cur_mos_r <= 1'b0;
      cur_fcs_r <= 1'b0;
      cur_sel_r <= 1'b0;
      cur_len_r <= '0;
      idx_r <= '0;
      rep_r <= '0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
          if (take && pend_r)
          begin
            cur_mos_r <= pend_mos_r;
            cur_fcs_r <= fcs_en_r && pend_mos_r;
            cur_sel_r <= pend_sel_r;
            cur_len_r <= pend_len_r;
            idx_r <= '0;
            rep_r <= '0;
            state_r <= ST_MREAD;
          end
        ST_MREAD:
          if (len_zero)
            state_r <= ST_IDLE;
          else
            state_r <= cur_mos_r ? ST_MPUSH : ST_BLEAD;
        ST_MPUSH:
          if (take)
          begin
            idx_r <= idx_inc;
            if (!last_oct)
              state_r <= ST_MREAD;
            else
              state_r <= cur_fcs_r ? ST_CRC : ST_IDLE;
          end
        ST_CRC:
          if (take)
            state_r <= ST_IDLE;
        ST_BLEAD:
          if (take)
            state_r <= ST_BCODE;
        ST_BCODE:
          if (take)
          begin
            rep_r <= rep_inc;
            state_r <= (bos_done || bos_stop) ? ST_IDLE : ST_BLEAD;
          end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // =====================================================
  // message buffers and line shifter
  assign mem_ch.we = wr_buf;
  assign mem_ch.waddr = {wr_idx[BUF_SEL_BIT], wr_idx[CNT_W-1:0]};
  assign mem_ch.wdata = w_data_r;
  assign mem_ch.re = (state_r == ST_MREAD);
  assign mem_ch.raddr = {cur_sel_r, idx_r};

  dtx_msg_ram u_ram (
    .clk_i (clk_i),
    .m (mem_ch.mem)
  );

  dtx_bit_shifter u_shift (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .bit_en_i (bit_en),
    .b (byte_ch.snk),
    .dl_data_o (dl_data_o)
  );
endmodule

//--- dtx_top_checker.sv
`timescale 1ns/1ps
// ==========================================
// port checks for the data link transmitter
module dtx_top_checker #(
  parameter int BIT_CYC = 20
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic dl_data_o,
  input wire logic dl_bit_en_o
);
  int gap_r;
  logic seen_r;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // cycles since the last bit slot
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      gap_r <= 0;
    else
      gap_r <= dl_bit_en_o ? 0 : gap_r + 1;
  end
  // first slot seen since reset
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      seen_r <= 1'b0;
    else if (dl_bit_en_o)
      seen_r <= 1'b1;
  end
  sequence s_wr_taken;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  chk_slot_spacing: assert property (seen_r |-> dl_bit_en_o == (gap_r == BIT_CYC - 1))
    else $error("bit slot spacing wrong");
  chk_line_bit_hold: assert property ($changed(dl_data_o) |-> $past(dl_bit_en_o))
    else $error("line bit changed outside a slot");
  chk_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid_o)
    else $error("write answer late");
  chk_read_answer: assert property (s_rd_taken |=> s_axi_rvalid_o)
    else $error("read answer late");
  chk_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write answer dropped early");
  chk_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read answer dropped early");
  chk_bvalid_done: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
    else $error("write answer not released");
  chk_ar_blocked: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken while answer pending");
  chk_rdata_upper: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h000000)
    else $error("read data upper bits set");
endmodule

bind dtx_top dtx_top_checker #(.BIT_CYC(BIT_CYC)) i_dtx_top_checker (
  .clk_i(clk_i), .rst_i(rst_i), .s_axi_awvalid_i(s_axi_awvalid_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
  .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
  .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i), .dl_data_o(dl_data_o), .dl_bit_en_o(dl_bit_en_o)
);

//--- dtx_line_rx.sv
`timescale 1ns/1ps
// ==========================================
// remote receiver: flag hunt, zero removal, octets
module dtx_line_rx (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic line_i,
  input wire logic slot_i,
  input wire logic [7:0] code_i,
  output logic [15:0] flags_o,
  output logic [15:0] bos_o,
  output logic [7:0] frames_o,
  output logic [7:0] len_o
);
  import dtx_pkg::*;
  logic [15:0] sh;
  logic [7:0] acc;
  logic [7:0] oct [0:15];
  logic inf;
  logic b;
  int skip, ones, nb, n;
  // bit taken at each slot, delayed eight bits behind the flag window
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sh = '0;
      inf = 1'b0;
      skip = 0;
      flags_o <= '0;
      bos_o <= '0;
      frames_o <= '0;
      len_o <= '0;
    end
    else if (slot_i)
    begin
      sh = {line_i, sh[15:1]};
      b = sh[7];
      if (sh == {code_i, 8'hFF})
        bos_o <= bos_o + 16'h1;
      if (skip > 0)
        skip--;
      else if (inf && ones == 5 && !b)
        ones = 0; // stuffed zero dropped
      else if (inf)
      begin
        ones = b ? ones + 1 : 0;
        inf = ones < 7; // seven ones abort the frame
        acc = {b, acc[7:1]};
        nb = (nb + 1) % 8;
        if (nb == 0)
        begin
          oct[n % 16] = acc;
          n++;
        end
      end
      if (sh[15:8] == FLAG_OCTET)
      begin
        flags_o <= flags_o + 16'h1;
        if (inf && nb == 0 && n > 0)
        begin
          frames_o <= frames_o + 8'h1;
          len_o <= 8'(n);
        end
        inf = 1'b1;
        skip = 8;
        n = 0;
        nb = 0;
        ones = 0;
      end
    end
  end
endmodule

//--- dtx_top_bench.sv
`timescale 1ns/1ps
// ==========================================
// register-level bench for the data link transmitter
module dtx_top_bench;
  import dtx_pkg::*;
  localparam int BC = 20;
  localparam logic [15:0] A_CTL = {2'b00, IDX_DL_CTRL, 2'b00};
  localparam logic [15:0] A_CNT = {2'b00, IDX_BYTE_CNT, 2'b00};
  localparam logic [15:0] A_ST = {2'b00, IDX_IRQ_STAT, 2'b00};
  localparam logic [15:0] A_MSK = {2'b00, IDX_IRQ_MASK, 2'b00};
  localparam logic [15:0] A_B0 = {2'b00, IDX_BUF0, 2'b00};
  logic clk_i, rst_i, awv, wv, br, arv, rr, awrdy, wrdy, bvld, ardy, rvld, dl, slot, irq;
  logic [15:0] aw, ar, flags, bit_oriented_signalling;
  logic [31:0] wd, rdata;
  logic [1:0] bresp, rresp;
  logic [7:0] frames, len;
  logic [7:0] pay [0:3] = '{8'h03, 8'h7E, 8'hFF, 8'hC1};
  int bad_count, comparisons;
  dtx_top #(.BIT_CYC(BC)) i_dtx_top (
    .clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr_i(aw), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awrdy), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wrdy), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvld), .s_axi_bready_i(br),
    .s_axi_araddr_i(ar), .s_axi_arvalid_i(arv), .s_axi_arready_o(ardy),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvld),
    .s_axi_rready_i(rr), .dl_data_o(dl), .dl_bit_en_o(slot), .tx_end_of_transfer_irq_o(irq));
  dtx_line_rx i_dtx_line_rx (.clk_i(clk_i), .rst_i(rst_i), .line_i(dl), .slot_i(slot),
    .code_i(8'h12), .flags_o(flags), .bos_o(bit_oriented_signalling), .frames_o(frames), .len_o(len));
  // 40 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // ==========================================
  // checking and closing
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // one clock of a capped wait
  task automatic step(inout int t);
    @(posedge clk_i);
    t++;
    if (t > 4000)
    begin
      bad_count++;
      $display("[FAIL] wait expected done seen timeout");
      finish_test();
    end
  endtask
  // ==========================================
  // register bus cycles
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    int t;
    t = 0;
    aw <= a;
    wd <= {24'h000000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    while (bvld !== 1'b1)
    begin
      step(t);
      if (awv && awrdy) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
    end
    chk("bresp", {30'h0, bresp}, {30'h0, RESP_OKAY});
    br <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic [1:0] er);
    int t;
    t = 0;
    ar <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    while (rvld !== 1'b1)
    begin
      step(t);
      if (arv && ardy) arv <= 1'b0;
    end
    chk("rdata", rdata, {24'h000000, e});
    chk("rresp", {30'h0, rresp}, {30'h0, er});
    rr <= 1'b0;
    @(posedge clk_i);
  endtask
  // ==========================================
  // frame expectations
  function automatic logic [15:0] crc16(input int n, input logic sel);
    logic [15:0] c;
    int i, k;
    c = CRC_INIT;
    for (i = 0; i < n; i++)
    begin
      c ^= {8'h00, pay[i] ^ {8{sel}}};
      for (k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    return ~c;
  endfunction
  task automatic send(input logic [7:0] ctl, input logic sel, input int n);
    logic [7:0] f;
    int i, t;
    wr(A_CTL, ctl);
    for (i = 0; i < n; i++) wr(A_B0 + {5'h00, sel, 10'h000} + 16'(4 * i), pay[i] ^ {8{sel}});
    f = frames;
    t = 0;
    wr(A_CNT, {sel, 7'(n)});
    rd(A_CNT, {~sel, 7'(n)}, RESP_OKAY);
    while (frames === f) step(t);
    chk("length", {24'h0, len}, n + (ctl[1] ? 2 : 0));
    for (i = 0; i < n; i++) chk("octet", i_dtx_line_rx.oct[i], pay[i] ^ {8{sel}});
    if (ctl[1]) chk("crc", {i_dtx_line_rx.oct[n + 1], i_dtx_line_rx.oct[n]}, crc16(n, sel));
  endtask
  // ==========================================
  // main sequence
  initial
  begin
    int t;
    logic [15:0] b;
    {rst_i, awv, wv, br, arv, rr} = 6'b100000;
    {aw, ar, wd} = '0;
    bad_count = 0;
    comparisons = 0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(A_CTL, 8'h00, RESP_OKAY);
    rd(A_CNT, 8'h00, RESP_OKAY);
    rd(16'h0100, 8'h00, RESP_SLVERR);
    rd(A_B0, 8'h00, RESP_OKAY);
    repeat (30 * BC) @(posedge clk_i);
    chk("idle flags", {31'h0, flags >= 2}, 1);
    // counted code with check octets asked for
    wr(A_B0, 8'h12);
    wr(A_MSK, 8'h01);
    wr(A_CNT, 8'h02);
    wr(A_CTL, 8'h02);
    t = 0;
    while (irq !== 1'b1) step(t);
    repeat (40 * BC) @(posedge clk_i);
    chk("code count", {16'h0, bit_oriented_signalling}, 2);
    rd(A_ST, 8'h01, RESP_OKAY);
    wr(A_ST, 8'h01);
    chk("irq clear", {31'h0, irq}, 0);
    // endless code until frames are chosen
    wr(A_CNT, 8'h00);
    wr(A_CTL, 8'h00);
    repeat (100 * BC) @(posedge clk_i);
    chk("endless", {31'h0, bit_oriented_signalling > 6}, 1);
    rd(A_ST, 8'h00, RESP_OKAY);
    wr(A_CTL, 8'h01);
    repeat (20 * BC) @(posedge clk_i);
    b = bit_oriented_signalling;
    repeat (40 * BC) @(posedge clk_i);
    chk("code stopped", {16'h0, bit_oriented_signalling}, {16'h0, b});
    // frames, masked and unmasked interrupt
    send(8'h03, 1'b0, 3);
    rd(A_ST, 8'h02, RESP_OKAY);
    chk("irq masked", {31'h0, irq}, 0);
    wr(A_MSK, 8'h03);
    chk("irq raised", {31'h0, irq}, 1);
    wr(A_ST, 8'h02);
    chk("irq cleared", {31'h0, irq}, 0);
    send(8'h01, 1'b1, 2);
    finish_test();
  end
endmodule
